// *** red_rail_gate.sv ***
// ============================================================
// Purpose: Enable gating and edge delay for rails four and five
// Assumes: Control and power-good inputs are asynchronous pins
// Notes:   Rail four enable request comes straight from its own pin, with no gating
// ============================================================
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
module red_rail_gate import red_pkg::*; #(
    parameter int CYCLES_PER_MS = CYCLES_PER_MS_DEF
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rd_data,
    input wire logic control_input_one,
    input wire logic control_input_two,
    input wire logic control_input_three,
    input wire logic control_input_four,
    input wire logic control_input_five,
    input wire logic control_input_six,
    input wire logic adjustable_ldo_three_power_good_flag,
    input wire logic adjustable_ldo_two_power_good_flag,
    input wire logic load_switch_a_one_power_good_flag,
    input wire logic converter_rail_six_power_good_flag,
    input wire logic converter_rail_four_power_good_flag,
    input wire logic converter_rail_three_power_good_flag,
    input wire logic converter_rail_two_power_good_flag,
    input wire logic converter_rail_one_power_good_flag,
    input wire logic switch_b_two_ldo_one_shared_power_good_flag,
    input wire logic load_switch_b_one_power_good_flag,
    input wire logic converter_rail_four_enable_request,
    output logic converter_rail_four_enable,
    output logic converter_rail_five_enable
);
    localparam int CTL_N = 6;
    localparam int PGA_N = 8;
    localparam int PGB_N = 2;
    localparam int SYNC_N = CTL_N + PGA_N + PGB_N + 1;

    // ============================================================
    // Registers
    logic [DATA_W-1:0] rail4_enable_edge_delay;
    logic [DATA_W-1:0] rail5_powergood_mask;
    logic [DATA_W-1:0] rail5_enable_source_and_mask;
    logic [DATA_W-1:0] rail5_enable_edge_delay;

    logic [SYNC_N-1:0] raw_pins;
    logic [SYNC_N-1:0] sync_pins;
    logic [CTL_N-1:0] ctl_sync;
    logic [PGA_N-1:0] pga_sync;
    logic [PGB_N-1:0] pgb_sync;
    logic rail4_request_sync;

    logic [DLY_W-1:0] rail4_on_delay;
    logic [DLY_W-1:0] rail4_off_delay;
    logic [DLY_W-1:0] rail5_on_delay;
    logic [DLY_W-1:0] rail5_off_delay;
    logic [SEL_W-1:0] rail_five_enable_source;
    logic [PGB_N-1:0] rail5_mask_b;

    logic next_rail_five_request;
    logic rail_five_request;
    logic rail4_pending;
    logic rail5_pending;
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] next_rd_data;

    // ============================================================
    // Pin synchronisation
    assign raw_pins = {
        converter_rail_four_enable_request,
        switch_b_two_ldo_one_shared_power_good_flag,
        load_switch_b_one_power_good_flag,
        adjustable_ldo_three_power_good_flag,
        adjustable_ldo_two_power_good_flag,
        load_switch_a_one_power_good_flag,
        converter_rail_six_power_good_flag,
        converter_rail_four_power_good_flag,
        converter_rail_three_power_good_flag,
        converter_rail_two_power_good_flag,
        converter_rail_one_power_good_flag,
        control_input_six,
        control_input_five,
        control_input_four,
        control_input_three,
        control_input_two,
        control_input_one
    };

    red_sync #(
        .WIDTH(SYNC_N)
    ) u_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .async_in(raw_pins),
        .sync_out(sync_pins)
    );

    assign ctl_sync = sync_pins[CTL_N-1:0];
    assign pga_sync = sync_pins[CTL_N+PGA_N-1:CTL_N];
    assign pgb_sync = sync_pins[CTL_N+PGA_N+PGB_N-1:CTL_N+PGA_N];
    assign rail4_request_sync = sync_pins[SYNC_N-1];

    // ============================================================
    // Field extraction
    assign rail4_off_delay = rail4_enable_edge_delay[FALL_LSB+:DLY_W];
    assign rail4_on_delay = rail4_enable_edge_delay[RISE_LSB+:DLY_W];
    assign rail5_off_delay = rail5_enable_edge_delay[FALL_LSB+:DLY_W];
    assign rail5_on_delay = rail5_enable_edge_delay[RISE_LSB+:DLY_W];
    assign rail_five_enable_source = rail5_enable_source_and_mask[SEL_LSB+:SEL_W];
    assign rail5_mask_b = rail5_enable_source_and_mask[PGB_N-1:0];

    // ============================================================
    // Register writes
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rail4_enable_edge_delay <= RST_REG;
        end else if (wr_en && addr == OFS_RAIL4_DELAY) begin
            rail4_enable_edge_delay <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rail5_powergood_mask <= RST_REG;
        end else if (wr_en && addr == OFS_RAIL5_MASK) begin
            rail5_powergood_mask <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rail5_enable_source_and_mask <= RST_REG;
        end else if (wr_en && addr == OFS_RAIL5_SRC) begin
            rail5_enable_source_and_mask <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rail5_enable_edge_delay <= RST_REG;
        end else if (wr_en && addr == OFS_RAIL5_DELAY) begin
            rail5_enable_edge_delay <= wr_data;
        end
    end

    // ============================================================
    // Register reads: data only in the cycle after the strobe
    always_comb begin
        status = '0;
        status[STAT_RAIL4_EN] = converter_rail_four_enable;
        status[STAT_RAIL5_EN] = converter_rail_five_enable;
        status[STAT_RAIL5_REQ] = rail_five_request;
        status[STAT_RAIL4_PEND] = rail4_pending;
        status[STAT_RAIL5_PEND] = rail5_pending;
        unique case (addr)
            OFS_RAIL4_DELAY: next_rd_data = rail4_enable_edge_delay;
            OFS_RAIL5_MASK: next_rd_data = rail5_powergood_mask;
            OFS_RAIL5_SRC: next_rd_data = rail5_enable_source_and_mask;
            OFS_RAIL5_DELAY: next_rd_data = rail5_enable_edge_delay;
            OFS_STATUS: next_rd_data = status;
            default: next_rd_data = READ_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= READ_IDLE;
        end else begin
            rd_data <= rd_en ? next_rd_data : READ_IDLE;
        end
    end

    // ============================================================
    // Rail five enable gating
    function automatic logic pick_source(
        input logic [SEL_W-1:0] sel,
        input logic [CTL_N-1:0] ctl
    );
        unique case (sel)
            SEL_IN_ONE: pick_source = ctl[0];
            SEL_IN_TWO: pick_source = ctl[1];
            SEL_IN_FIVE: pick_source = ctl[4];
            SEL_IN_FOUR: pick_source = ctl[3];
            SEL_IN_THREE: pick_source = ctl[2];
            SEL_IN_THREE_FOUR: pick_source = ctl[2] & ctl[3];
            SEL_IN_SIX: pick_source = ctl[5];
            SEL_ALWAYS: pick_source = 1'b1;
        endcase
    endfunction : pick_source

    // A set mask bit forces its term true
    // Second group of terms
    always_comb begin
        next_rail_five_request = pick_source(rail_five_enable_source, ctl_sync)
            & (&(pga_sync | rail5_powergood_mask))
            & (&(pgb_sync | rail5_mask_b));
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rail_five_request <= 1'b0;
        end else begin
            rail_five_request <= next_rail_five_request;
        end
    end

    // ============================================================
    // Edge delays
    red_edge_delay #(
        .CYCLES_PER_MS(CYCLES_PER_MS),
        .CNT_W(DLY_CNT_W)
    ) u_rail_four_delay (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .level_in(rail4_request_sync),
        .rise_code(rail4_on_delay),
        .fall_code(rail4_off_delay),
        .level_out(converter_rail_four_enable),
        .pending(rail4_pending)
    );

    red_edge_delay #(
        .CYCLES_PER_MS(CYCLES_PER_MS),
        .CNT_W(DLY_CNT_W)
    ) u_rail_five_delay (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .level_in(rail_five_request),
        .rise_code(rail5_on_delay),
        .fall_code(rail5_off_delay),
        .level_out(converter_rail_five_enable),
        .pending(rail5_pending)
    );

    // ============================================================
    // Assertions
    property p_off_none;
        @(posedge ref_clk) disable iff (!nrst)
        !rail4_request_sync && converter_rail_four_enable && rail4_off_delay == DLY_NONE
        |=> !converter_rail_four_enable;
    endproperty
    a_off_none: assert property (p_off_none) else $error("rail four off without delay late");

    property p_off_wait;
        @(posedge ref_clk) disable iff (!nrst)
        $fell(rail4_request_sync) && converter_rail_four_enable && rail4_off_delay != DLY_NONE
        |=> converter_rail_four_enable [*2];
    endproperty
    a_off_wait: assert property (p_off_wait) else $error("rail four off delay skipped");

    property p_on_wait;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(rail4_request_sync) && !converter_rail_four_enable && rail4_on_delay != DLY_NONE
        |=> !converter_rail_four_enable [*2];
    endproperty
    a_on_wait: assert property (p_on_wait) else $error("rail four on delay skipped");

    property p_ldo3;
        @(posedge ref_clk) disable iff (!nrst)
        !rail5_powergood_mask[MSK_LDO3] && !pga_sync[MSK_LDO3] |=> !rail_five_request;
    endproperty
    a_ldo3: assert property (p_ldo3) else $error("LDO three term ignored");

    property p_ldo2;
        @(posedge ref_clk) disable iff (!nrst)
        !rail5_powergood_mask[MSK_LDO2] && !pga_sync[MSK_LDO2] |=> !rail_five_request;
    endproperty
    a_ldo2: assert property (p_ldo2) else $error("LDO two term ignored");

    property p_sw_a_one;
        @(posedge ref_clk) disable iff (!nrst)
        !rail5_powergood_mask[MSK_SW_A_ONE] && !pga_sync[MSK_SW_A_ONE] |=> !rail_five_request;
    endproperty
    a_sw_a_one: assert property (p_sw_a_one) else $error("switch A one term ignored");

    property p_rail6;
        @(posedge ref_clk) disable iff (!nrst)
        !rail5_powergood_mask[MSK_RAIL6] && !pga_sync[MSK_RAIL6] |=> !rail_five_request;
    endproperty
    a_rail6: assert property (p_rail6) else $error("rail six term ignored");

    property p_rail4;
        @(posedge ref_clk) disable iff (!nrst)
        !rail5_powergood_mask[MSK_RAIL4] && !pga_sync[MSK_RAIL4] |=> !rail_five_request;
    endproperty
    a_rail4: assert property (p_rail4) else $error("rail four term ignored");

    property p_rail3;
        @(posedge ref_clk) disable iff (!nrst)
        !rail5_powergood_mask[MSK_RAIL3] && !pga_sync[MSK_RAIL3] |=> !rail_five_request;
    endproperty
    a_rail3: assert property (p_rail3) else $error("rail three term ignored");

    property p_rail2;
        @(posedge ref_clk) disable iff (!nrst)
        !rail5_powergood_mask[MSK_RAIL2] && !pga_sync[MSK_RAIL2] |=> !rail_five_request;
    endproperty
    a_rail2: assert property (p_rail2) else $error("rail two term ignored");

    property p_rail1;
        @(posedge ref_clk) disable iff (!nrst)
        !rail5_powergood_mask[MSK_RAIL1] && !pga_sync[MSK_RAIL1] |=> !rail_five_request;
    endproperty
    a_rail1: assert property (p_rail1) else $error("rail one term ignored");

    property p_swb2;
        @(posedge ref_clk) disable iff (!nrst)
        !rail5_mask_b[SRC_SWB2_LDO1] && !pgb_sync[SRC_SWB2_LDO1] |=> !rail_five_request;
    endproperty
    a_swb2: assert property (p_swb2) else $error("shared switch term ignored");

    property p_sw_b_one;
        @(posedge ref_clk) disable iff (!nrst)
        !rail5_mask_b[SRC_SW_B_ONE] && !pgb_sync[SRC_SW_B_ONE] |=> !rail_five_request;
    endproperty
    a_sw_b_one: assert property (p_sw_b_one) else $error("switch B one term ignored");

    property p_sel_pair;
        @(posedge ref_clk) disable iff (!nrst)
        rail_five_enable_source == SEL_IN_THREE_FOUR && !(ctl_sync[2] && ctl_sync[3])
        |=> !rail_five_request;
    endproperty
    a_sel_pair: assert property (p_sel_pair) else $error("paired source not required");

    property p_sel_five;
        @(posedge ref_clk) disable iff (!nrst)
        rail_five_enable_source == SEL_IN_FIVE && !ctl_sync[4] |=> !rail_five_request;
    endproperty
    a_sel_five: assert property (p_sel_five) else $error("source code 2 misrouted");

    property p_always;
        @(posedge ref_clk) disable iff (!nrst)
        rail_five_enable_source == SEL_ALWAYS && (&(pga_sync | rail5_powergood_mask))
        && (&(pgb_sync | rail5_mask_b)) |=> rail_five_request;
    endproperty
    a_always: assert property (p_always) else $error("constant source did not enable");

    property p_rise_cause;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(converter_rail_five_enable) |-> $past(rail_five_request);
    endproperty
    a_rise_cause: assert property (p_rise_cause) else $error("rail five rose without request");

endmodule : red_rail_gate

// *** red_pkg.sv ***
// ============================================================
// Purpose: Constants for rail enable gating and edge delay
// Assumes: 100 MHz ref_clk, byte-wide register port
// Notes:   Delay codes share one decode for both rails
// ============================================================
// Summary of operation
// - Rail four off-delay field in bits 5:3
// - Rail four on-delay field in bits 2:0
// - Mask bit 7 drops adjustable LDO three
// - Mask bit 6 drops adjustable LDO two
// - Mask bit 5 drops load switch A one
// - Mask bit 4 drops converter rail six
// - Mask bit 3 drops converter rail four
// - Mask bit 2 drops converter rail three
// - Mask bit 1 drops converter rail two
// - Mask bit 0 drops converter rail one
// - Source bit 1 drops shared switch/LDO
// - Source bit 0 drops load switch B one
// - Bits 4:2 pick rail five control input
// - Code 111 feeds constant one, no pin
package red_pkg;

    // ============================================================
    // Register map
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFS_RAIL4_DELAY = 8'h12;
    localparam logic [ADDR_W-1:0] OFS_RAIL5_MASK = 8'h13;
    localparam logic [ADDR_W-1:0] OFS_RAIL5_SRC = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_RAIL5_DELAY = 8'h15;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
    localparam logic [DATA_W-1:0] RST_REG = 8'h00;
    localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

    // ============================================================
    // Field positions
    localparam int DLY_W = 3;
    localparam int FALL_LSB = 3;
    localparam int RISE_LSB = 0;
    localparam int SEL_W = 3;
    localparam int SEL_LSB = 2;
    localparam int MSK_LDO3 = 7;
    localparam int MSK_LDO2 = 6;
    localparam int MSK_SW_A_ONE = 5;
    localparam int MSK_RAIL6 = 4;
    localparam int MSK_RAIL4 = 3;
    localparam int MSK_RAIL3 = 2;
    localparam int MSK_RAIL2 = 1;
    localparam int MSK_RAIL1 = 0;
    localparam int SRC_SWB2_LDO1 = 1;
    localparam int SRC_SW_B_ONE = 0;
    localparam int STAT_RAIL4_EN = 0;
    localparam int STAT_RAIL5_EN = 1;
    localparam int STAT_RAIL5_REQ = 2;
    localparam int STAT_RAIL4_PEND = 3;
    localparam int STAT_RAIL5_PEND = 4;

    // ============================================================
    // Enable source codes
    localparam logic [SEL_W-1:0] SEL_IN_ONE = 3'h0;
    localparam logic [SEL_W-1:0] SEL_IN_TWO = 3'h1;
    localparam logic [SEL_W-1:0] SEL_IN_FIVE = 3'h2;
    localparam logic [SEL_W-1:0] SEL_IN_FOUR = 3'h3;
    localparam logic [SEL_W-1:0] SEL_IN_THREE = 3'h4;
    localparam logic [SEL_W-1:0] SEL_IN_THREE_FOUR = 3'h5;
    localparam logic [SEL_W-1:0] SEL_IN_SIX = 3'h6;
    localparam logic [SEL_W-1:0] SEL_ALWAYS = 3'h7;

    // ============================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_MS = 1000000;
    localparam int CYCLES_PER_MS_DEF = NS_PER_MS / CLK_PERIOD_NS;
    localparam int DLY_CNT_W = 23;
    localparam logic [DLY_W-1:0] DLY_NONE = 3'h0;

    // Delay code to milliseconds; code 6 taken as 32 ms on both edges
    function automatic int delay_ms(input logic [DLY_W-1:0] code);
        case (code)
            3'h0: delay_ms = 0;
            3'h1: delay_ms = 2;
            3'h2: delay_ms = 4;
            3'h3: delay_ms = 8;
            3'h4: delay_ms = 16;
            3'h5: delay_ms = 24;
            3'h6: delay_ms = 32;
            default: delay_ms = 64;
        endcase
    endfunction : delay_ms

endpackage : red_pkg

// *** red_sync.sv ***
// ============================================================
// Purpose: Two-flop synchroniser for pin-level inputs
// Assumes: Inputs are slow levels
// Notes:   First stage feeds only the second stage
// ============================================================
`timescale 1ns/10ps
module red_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stage_one <= '0;
            sync_out <= '0;
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end
endmodule : red_sync

// *** red_edge_delay.sv ***
// ============================================================
// Purpose: Delays rising and falling edges of an enable level
// Assumes: level_in is on ref_clk
// Notes:   A change that reverts before expiry is dropped
// ============================================================
`timescale 1ns/10ps
module red_edge_delay import red_pkg::*; #(
    parameter int CYCLES_PER_MS = CYCLES_PER_MS_DEF,
    parameter int CNT_W = DLY_CNT_W
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic level_in,
    input wire logic [DLY_W-1:0] rise_code,
    input wire logic [DLY_W-1:0] fall_code,
    output logic level_out,
    output logic pending
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] target;

    always_comb begin
        target = CNT_W'(delay_ms(level_in ? rise_code : fall_code) * CYCLES_PER_MS);
        pending = level_in != level_out;
    end

    // Output takes the new level target+1 cycles after the change is seen
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
            level_out <= 1'b0;
        end else if (!pending) begin
            count <= '0;
        end else if (count >= target) begin
            count <= '0;
            level_out <= level_in;
        end else begin
            count <= count + CNT_W'(1);
        end
    end
endmodule : red_edge_delay

// *** red_pins_model.sv ***
// Purpose: Far-side pins: control inputs, power-good flags, rail four request
// Assumes: Commands from the bench are applied one edge later, as async pins would move
// Notes:   Levels only; no pin ever floats
`timescale 1ns/10ps
module red_pins_model (
    input wire logic ref_clk,
    input wire logic [5:0] ctl_cmd,
    input wire logic [9:0] pg_cmd,
    input wire logic req_cmd,
    output logic [5:0] ctl_pin,
    output logic [9:0] pg_pin,
    output logic req_pin
);
    initial begin
        ctl_pin = 6'h00;
        pg_pin = 10'h000;
        req_pin = 1'b0;
    end
    always @(posedge ref_clk) begin
        ctl_pin <= ctl_cmd;
        pg_pin <= pg_cmd;
        req_pin <= req_cmd;
    end
endmodule : red_pins_model

// *** tb.sv ***
// Purpose: Self-checking bench for rail enable gating and edge delay
// Assumes: CYCLES_PER_MS reduced to 10
// Notes:   pg bits 7:0 follow mask bits, 9 shared switch/LDO, 8 switch B one
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); n_fail++; end end
module tb;
    import red_pkg::*;
    localparam int CPM = 10;
    logic ref_clk = 0, nrst = 0, wr_en = 0, rd_en = 0, req_cmd = 0, req_pin, en4, en5;
    logic [7:0] addr = 8'h00, wr_data = 8'h00, rd_data, rv;
    logic [5:0] ctl_cmd = 6'h00, ctl_pin;
    logic [9:0] pg_cmd = 10'h000, pg_pin;
    int n_fail = 0, checks_done = 0;
    int ms_tab[8] = '{0, 2, 4, 8, 16, 24, 32, 64};
    logic [5:0] pins[8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0C, 6'h20, 6'h00};
    always #5 ref_clk = ~ref_clk;
    red_pins_model red_pins_model_inst (.ref_clk(ref_clk), .ctl_cmd(ctl_cmd), .pg_cmd(pg_cmd),
        .req_cmd(req_cmd), .ctl_pin(ctl_pin), .pg_pin(pg_pin), .req_pin(req_pin));
    red_rail_gate #(.CYCLES_PER_MS(CPM)) red_rail_gate_inst (.ref_clk(ref_clk), .nrst(nrst),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .control_input_one(ctl_pin[0]), .control_input_two(ctl_pin[1]),
        .control_input_three(ctl_pin[2]), .control_input_four(ctl_pin[3]),
        .control_input_five(ctl_pin[4]), .control_input_six(ctl_pin[5]),
        .adjustable_ldo_three_power_good_flag(pg_pin[7]),
        .adjustable_ldo_two_power_good_flag(pg_pin[6]),
        .load_switch_a_one_power_good_flag(pg_pin[5]),
        .converter_rail_six_power_good_flag(pg_pin[4]),
        .converter_rail_four_power_good_flag(pg_pin[3]),
        .converter_rail_three_power_good_flag(pg_pin[2]),
        .converter_rail_two_power_good_flag(pg_pin[1]),
        .converter_rail_one_power_good_flag(pg_pin[0]),
        .switch_b_two_ldo_one_shared_power_good_flag(pg_pin[9]),
        .load_switch_b_one_power_good_flag(pg_pin[8]),
        .converter_rail_four_enable_request(req_pin),
        .converter_rail_four_enable(en4), .converter_rail_five_enable(en5));
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a; wr_data <= d; wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a; rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask : rd
    // Rail five enable worked out from source, masks and power-good levels
    function automatic logic exp5(input logic [2:0] sel, input logic [5:0] c,
                                  input logic [9:0] pg, input logic [9:0] msk);
        logic src;
        src = (sel == 3'h7) ? 1'b1 : ((c & pins[sel]) == pins[sel]);
        return src & ((pg | msk) == 10'h3FF);
    endfunction : exp5
    task automatic apply5(input logic [2:0] sel, input logic [5:0] c,
                          input logic [9:0] pg, input logic [9:0] msk);
        wr(OFS_RAIL5_MASK, msk[7:0]);
        wr(OFS_RAIL5_SRC, {3'b000, sel, msk[9], msk[8]});
        @(posedge ref_clk);
        ctl_cmd <= c; pg_cmd <= pg;
        cyc(10);
        `CHK("rail5_enable", exp5(sel, c, pg, msk), en5)
    endtask : apply5
    task automatic t_regs;
        logic [7:0] a;
        for (int i = 0; i < 4; i++) begin
            a = OFS_RAIL4_DELAY + 8'(i);
            rd(a, rv);
            `CHK("reg_reset", 8'h00, rv)
            wr(a, 8'hA5 ^ 8'(i));
            rd(a, rv);
            `CHK("reg_rw", 8'hA5 ^ 8'(i), rv)
            cyc(1);
            `CHK("rd_idle", 8'h00, rd_data)
        end
        wr(8'h30, 8'hFF);
        rd(8'h30, rv);
        `CHK("unmapped", 8'h00, rv)
        wr(OFS_RAIL4_DELAY, 8'h00);
        wr(OFS_RAIL5_DELAY, 8'h00);
    endtask : t_regs
    task automatic t_masks;
        for (int i = 0; i < 10; i++) begin
            apply5(3'h7, 6'h00, ~(10'h001 << i), 10'h000);
            apply5(3'h7, 6'h00, ~(10'h001 << i), 10'h001 << i);
        end
    endtask : t_masks
    task automatic t_sources;
        for (int s = 0; s < 8; s++) begin
            apply5(3'(s), pins[s], 10'h3FF, 10'h000);
            apply5(3'(s), ~pins[s], 10'h3FF, 10'h000);
            apply5(3'(s), 6'h04, 10'h3FF, 10'h000);
        end
    endtask : t_sources
    task automatic t_delay(input logic lvl);
        int t;
        int k;
        for (int c = 0; c < 8; c++) begin
            wr(OFS_RAIL4_DELAY, {2'b00, 3'(c), 3'(c)});
            t = ms_tab[c] * CPM;
            @(posedge ref_clk);
            req_cmd <= lvl;
            cyc(t + 2);
            `CHK("rail4_early", !lvl, en4)
            k = 0;
            while (en4 !== lvl && k < 6) begin
                cyc(1);
                k++;
            end
            `CHK("rail4_late", lvl, en4)
            if (!lvl && c < 7) begin
                @(posedge ref_clk);
                req_cmd <= 1'b1;
                cyc(ms_tab[c + 1] * CPM + 8);
            end
        end
    endtask : t_delay
    task automatic test_done;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        t_regs();
        t_masks();
        t_sources();
        for (int c = 0; c < 8; c++) begin
            wr(OFS_RAIL4_DELAY, {5'b00000, 3'(c)});
            @(posedge ref_clk);
            req_cmd <= 1'b0;
            cyc(8);
            @(posedge ref_clk);
            req_cmd <= 1'b1;
            cyc(ms_tab[c] * CPM + 2);
            `CHK("rail4_rise_early", 1'b0, en4)
            cyc(6);
            `CHK("rail4_rise", 1'b1, en4)
        end
        rd(OFS_STATUS, rv);
        `CHK("status", 8'h07, rv)
        wr(OFS_STATUS, 8'hFF);
        rd(OFS_STATUS, rv);
        `CHK("status_ro", 8'h07, rv)
        t_delay(1'b0);
        test_done();
    end
    initial begin
        #200000;
        n_fail++;
        test_done();
    end
endmodule : tb
